// [hdl/rss_rail_regs.sv]
`timescale 1ns/100ps
`include "rss_defs.svh"
module rss_rail_regs #(
	parameter int OUTPUTS = 2
)(
	input wire logic sys_clk_in,
	input wire logic srst_in,
	input wire logic cmd_valid_in,
	input wire logic cmd_write_in,
	input wire rss_pkg::rss_cmd_type cmd_code_in,
	input wire rss_pkg::rss_word_type cmd_wdata_in,
	output rss_pkg::rss_word_type rd_data_out,
	output logic rd_valid_out,
	output logic cmd_reject_out,
	output logic commit_out,
	output logic [$clog2(OUTPUTS)-1:0] page_out,
	input wire logic [OUTPUTS-1:0] rail_on_in,
	input wire logic [OUTPUTS-1:0] power_good_in,
	input wire logic [OUTPUTS-1:0] vout_ov_in,
	input wire logic [OUTPUTS-1:0] vout_uv_in,
	input wire logic [OUTPUTS-1:0] vout_ceil_in,
	input wire logic [OUTPUTS-1:0] iout_oc_in,
	input wire logic vin_uv_in,
	input wire logic input_fault_in,
	input wire logic temp_in,
	input wire logic cml_in,
	input wire logic mfr_in,
	input wire logic other_in,
	input wire logic [OUTPUTS-1:0][15:0] vout_target_in,
	output logic [OUTPUTS-1:0][15:0] ramp_up_out,
	output logic [OUTPUTS-1:0][15:0] turnoff_delay_out,
	output logic [OUTPUTS-1:0][15:0] ramp_down_out,
	output logic [OUTPUTS-1:0][15:0] ramp_target_out
);
	localparam int PG_W = $clog2(OUTPUTS);
	localparam logic [15:0] OUT_CNT = 16'(OUTPUTS);

	logic [PG_W-1:0] page_reg;
	logic [15:0] pend_rise [OUTPUTS];
	logic [15:0] pend_dly [OUTPUTS];
	logic [15:0] pend_fall [OUTPUTS];
	logic [15:0] act_rise [OUTPUTS];
	logic [15:0] act_dly [OUTPUTS];
	logic [15:0] act_fall [OUTPUTS];
	logic [15:0] act_tgt [OUTPUTS];
	logic [7:0] vdet_reg [OUTPUTS];
	logic [7:0] idet_reg [OUTPUTS];
	logic [7:0] vdet_next [OUTPUTS];
	logic [7:0] idet_next [OUTPUTS];
	logic [7:0] sum_byte_reg;
	logic [7:0] sum_byte_next;
	// Indexed by high-byte bit position, so bits 15..11 land at 7..3
	logic [7:3] sum_hi_reg;
	logic [7:3] sum_hi_next;
	logic [OUTPUTS-1:0] v_any;
	logic [OUTPUTS-1:0] i_any;
	logic wr;
	logic rd;
	logic acc_ok;
	logic commit;
	logic [15:0] rd_next;

	assign wr = cmd_valid_in && cmd_write_in;
	assign rd = cmd_valid_in && !cmd_write_in;
	assign commit = wr && cmd_code_in == `RSS_CMD_COMMIT;
	assign page_out = page_reg;

	// Decode; anything not accepted only raises cmd_reject_out and leaves settings, page and read data untouched
	always_comb begin
		acc_ok = 1'b0;
		unique case (cmd_code_in)
			`RSS_CMD_PAGE: begin
				acc_ok = !cmd_write_in || cmd_wdata_in < OUT_CNT;
			end
			`RSS_CMD_RISE, `RSS_CMD_FALL: begin
				acc_ok = !cmd_write_in ||
					cmd_wdata_in <= `RSS_RAMP_MAX;
			end
			`RSS_CMD_TOFF_DLY: begin
				acc_ok = !cmd_write_in ||
					cmd_wdata_in <= `RSS_DLY_MAX;
			end
			`RSS_CMD_SUM_B, `RSS_CMD_SUM_W, `RSS_CMD_VDET: begin
				acc_ok = !cmd_write_in;
			end
			`RSS_CMD_COMMIT: begin
				acc_ok = cmd_write_in;
			end
			default: begin
				acc_ok = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			page_reg <= '0;
		end else if (wr && acc_ok && cmd_code_in == `RSS_CMD_PAGE) begin
			page_reg <= cmd_wdata_in[PG_W-1:0];
		end
	end

	genvar j;
	generate
		for (j = 0; j < OUTPUTS; j++) begin : g_out
			logic sel;
			assign sel = wr && acc_ok && page_reg == PG_W'(j);

			// Written values wait here until the commit command
			always_ff @(posedge sys_clk_in) begin
				if (srst_in) begin
					pend_rise[j] <= `RSS_RISE_RST;
					pend_dly[j] <= `RSS_DLY_RST;
					pend_fall[j] <= `RSS_FALL_RST;
				end else if (sel) begin
					if (cmd_code_in == `RSS_CMD_RISE) begin
						pend_rise[j] <= cmd_wdata_in;
					end
					if (cmd_code_in == `RSS_CMD_TOFF_DLY) begin
						pend_dly[j] <= cmd_wdata_in;
					end
					if (cmd_code_in == `RSS_CMD_FALL) begin
						pend_fall[j] <= cmd_wdata_in;
					end
				end
			end

			// Ramp engine sees only committed values
			always_ff @(posedge sys_clk_in) begin
				if (srst_in) begin
					act_rise[j] <= `RSS_RISE_RST;
					act_dly[j] <= `RSS_DLY_RST;
					act_fall[j] <= `RSS_FALL_RST;
					act_tgt[j] <= 16'h0000;
				end else if (commit) begin
					act_rise[j] <= pend_rise[j];
					act_dly[j] <= pend_dly[j];
					act_fall[j] <= pend_fall[j];
					act_tgt[j] <= vout_target_in[j];
				end
			end

			assign ramp_up_out[j] = act_rise[j];
			assign turnoff_delay_out[j] = act_dly[j];
			assign ramp_down_out[j] = act_fall[j];
			assign ramp_target_out[j] = act_tgt[j];

			always_comb begin
				vdet_next[j] = 8'h00;
				vdet_next[j][`RSS_V_OV] = vout_ov_in[j];
				vdet_next[j][`RSS_V_UV] = vout_uv_in[j];
				vdet_next[j][`RSS_V_CEIL] = vout_ceil_in[j];
				idet_next[j] = 8'h00;
				idet_next[j][`RSS_I_OC] = iout_oc_in[j];
			end
			assign v_any[j] = |vdet_next[j];
			assign i_any[j] = |idet_next[j];

			// Status mirrors live conditions; no reset on purpose
			always_ff @(posedge sys_clk_in) begin
				vdet_reg[j] <= vdet_next[j];
				idet_reg[j] <= idet_next[j];
			end
		end
	endgenerate

	// Shared summaries gather both outputs whatever the page
	always_comb begin
		sum_byte_next = 8'h00;
		sum_byte_next[`RSS_B_OFF] = ~&rail_on_in;
		sum_byte_next[`RSS_B_OV] = |vout_ov_in;
		sum_byte_next[`RSS_B_OC] = |iout_oc_in;
		sum_byte_next[`RSS_B_VINUV] = vin_uv_in;
		sum_byte_next[`RSS_B_TEMP] = temp_in;
		sum_byte_next[`RSS_B_CML] = cml_in;
		sum_byte_next[`RSS_B_OTHER] = other_in;
		sum_hi_next = 5'h00;
		sum_hi_next[`RSS_W_VOUT] = |v_any;
		sum_hi_next[`RSS_W_IOUT] = |i_any;
		sum_hi_next[`RSS_W_INPUT] = input_fault_in | vin_uv_in;
		sum_hi_next[`RSS_W_MFR] = mfr_in;
		sum_hi_next[`RSS_W_PGN] = ~&power_good_in;
	end

	always_ff @(posedge sys_clk_in) begin
		sum_byte_reg <= sum_byte_next;
		sum_hi_reg <= sum_hi_next;
	end

	always_comb begin
		rd_next = 16'h0000;
		unique case (cmd_code_in)
			`RSS_CMD_PAGE: begin
				rd_next = 16'(page_reg);
			end
			`RSS_CMD_RISE: begin
				rd_next = pend_rise[page_reg];
			end
			`RSS_CMD_TOFF_DLY: begin
				rd_next = pend_dly[page_reg];
			end
			`RSS_CMD_FALL: begin
				rd_next = pend_fall[page_reg];
			end
			`RSS_CMD_SUM_B: begin
				rd_next = {8'h00, sum_byte_reg};
			end
			`RSS_CMD_SUM_W: begin
				// Low byte shares the summary byte register
				rd_next = {sum_hi_reg, 3'b000, sum_byte_reg};
			end
			`RSS_CMD_VDET: begin
				rd_next = {8'h00, vdet_reg[page_reg]};
			end
			default: begin
				rd_next = 16'h0000;
			end
		endcase
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			rd_data_out <= 16'h0000;
			rd_valid_out <= 1'b0;
		end else begin
			rd_valid_out <= rd && acc_ok;
			if (rd && acc_ok) begin
				rd_data_out <= rd_next;
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			cmd_reject_out <= 1'b0;
			commit_out <= 1'b0;
		end else begin
			cmd_reject_out <= cmd_valid_in && !acc_ok;
			commit_out <= commit;
		end
	end

	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (srst_in);

	hold_until_commit_a: assert property (
		!commit |=> $stable(act_rise[0]) && $stable(act_fall[1]))
		else $error("ramp setting changed without commit");

	commit_loads_a: assert property (
		commit |=> act_rise[1] == $past(pend_rise[1]) &&
			act_dly[0] == $past(pend_dly[0]))
		else $error("commit did not load pending value");

	commit_target_a: assert property (
		commit |=> act_tgt[0] == $past(vout_target_in[0]))
		else $error("commit did not refresh target");

	reset_values_a: assert property (
		$past(srst_in) |-> pend_rise[0] == `RSS_RISE_RST &&
			pend_fall[1] == `RSS_FALL_RST &&
			pend_dly[0] == `RSS_DLY_RST)
		else $error("setting reset value wrong");

	range_kept_a: assert property (
		pend_dly[0] <= `RSS_DLY_MAX && pend_rise[1] <= `RSS_RAMP_MAX)
		else $error("setting out of range");

	paged_read_a: assert property (
		rd && cmd_code_in == `RSS_CMD_VDET |=>
			rd_valid_out &&
			rd_data_out[7:0] == $past(vdet_reg[page_reg]))
		else $error("detail read wrong page");

	off_bit_a: assert property (
		!rail_on_in[1] |=> sum_byte_reg[`RSS_B_OFF])
		else $error("off bit clear while output off");

	low_bits_a: assert property (
		##1 sum_byte_reg[5:0] == $past({|vout_ov_in, |iout_oc_in,
			vin_uv_in, temp_in, cml_in, other_in}))
		else $error("summary low bits wrong");

	word_low_a: assert property (
		rd && cmd_code_in == `RSS_CMD_SUM_W |=>
			rd_data_out[7:0] == $past(sum_byte_reg))
		else $error("word low byte differs from byte");

	high_or_a: assert property (
		vout_uv_in[1] |=> sum_hi_reg[`RSS_W_VOUT] ##1 1'b1)
		else $error("voltage summary missed detail");

	pgood_bit_a: assert property (
		##1 sum_hi_reg[`RSS_W_PGN] == $past(~&power_good_in))
		else $error("power good bit wrong");

	detail_bits_a: assert property (
		##1 vdet_reg[0] == $past({vout_ov_in[0], 2'b00,
			vout_uv_in[0], vout_ceil_in[0], 3'b000}))
		else $error("voltage detail bits wrong");

	ro_write_a: assert property (
		wr && cmd_code_in == `RSS_CMD_SUM_W |=> cmd_reject_out)
		else $error("status write not refused");

	commit_cov: cover property (wr && cmd_code_in ==
		`RSS_CMD_RISE ##[1:20] commit);
	page_cov: cover property (wr && cmd_code_in ==
		`RSS_CMD_PAGE && cmd_wdata_in == 16'h0001);
	word_cov: cover property (rd && cmd_code_in ==
		`RSS_CMD_SUM_W ##1 rd_data_out[15]);
endmodule

// [inc/rss_defs.svh]
`ifndef RSS_DEFS_SVH
`define RSS_DEFS_SVH
// What this block does
// - Per-output ramp-up time, 1 us, reset 500
// - New ramp values wait for commit command
// - Commit also refreshes slope voltage target
// - Per-output turn-off delay, x10 us, reset 0
// - Per-output ramp-down time, 1 us, reset 500
// - Settings and voltage detail selected by page
// - Summary bit 6 set when output off
// - Bits 5,4,3: overvoltage, overcurrent, input UV
// - Bits 2,1,0: temperature, comm/logic, other
// - Summaries report faults of both outputs
// - Summary word low byte equals summary byte
// - Bits 15..12: voltage, current, input, maker
// - Bit 11 set while power not good
// - Voltage detail bits 7,4,3: OV, UV, ceiling
// - Status registers read-only, no reset value
// - Current detail bit 7 on overcurrent
`define RSS_CMD_PAGE 8'h00
`define RSS_CMD_RISE 8'h61
`define RSS_CMD_TOFF_DLY 8'h64
`define RSS_CMD_FALL 8'h65
`define RSS_CMD_SUM_B 8'h78
`define RSS_CMD_SUM_W 8'h79
`define RSS_CMD_VDET 8'h7a
`define RSS_CMD_COMMIT 8'he7
`define RSS_RISE_RST 16'h01f4
`define RSS_DLY_RST 16'h0000
`define RSS_FALL_RST 16'h01f4
`define RSS_RAMP_MAX 16'h2710
`define RSS_DLY_MAX 16'h03e8
`define RSS_B_OFF 6
`define RSS_B_OV 5
`define RSS_B_OC 4
`define RSS_B_VINUV 3
`define RSS_B_TEMP 2
`define RSS_B_CML 1
`define RSS_B_OTHER 0
`define RSS_W_VOUT 7
`define RSS_W_IOUT 6
`define RSS_W_INPUT 5
`define RSS_W_MFR 4
`define RSS_W_PGN 3
`define RSS_V_OV 7
`define RSS_V_UV 4
`define RSS_V_CEIL 3
`define RSS_I_OC 7
`endif

// [inc/rss_pkg.sv]
package rss_pkg;
	typedef logic [15:0] rss_word_type;
	typedef logic [7:0] rss_byte_type;
	typedef logic [7:0] rss_cmd_type;
endpackage

// [sim/rss_host_model.sv]
`timescale 1ns/100ps
module rss_host_model (
	input wire logic sys_clk_in,
	output logic cmd_valid_out,
	output logic cmd_write_out,
	output rss_pkg::rss_cmd_type cmd_code_out,
	output rss_pkg::rss_word_type cmd_wdata_out,
	input wire rss_pkg::rss_word_type rd_data_in,
	input wire logic rd_valid_in,
	input wire logic cmd_reject_in
);
	initial begin
		cmd_valid_out = 1'b0;
		cmd_write_out = 1'b0;
		cmd_code_out = 8'h00;
		cmd_wdata_out = 16'h0000;
	end
	// One-cycle strobe; idle lines inverted so stale values never match
	task automatic cmd(input logic wr, input rss_pkg::rss_cmd_type code,
		input rss_pkg::rss_word_type data,
		output rss_pkg::rss_word_type rdata, output logic ok,
		output logic rej);
		@(negedge sys_clk_in);
		cmd_valid_out = 1'b1;
		cmd_write_out = wr;
		cmd_code_out = code;
		cmd_wdata_out = data;
		@(negedge sys_clk_in);
		rdata = rd_data_in;
		ok = rd_valid_in;
		rej = cmd_reject_in;
		cmd_valid_out = 1'b0;
		cmd_write_out = ~wr;
		cmd_code_out = ~code;
		cmd_wdata_out = ~data;
	endtask
endmodule

// [sim/rss_rail_regs_tb.sv]
`timescale 1ns/100ps
module rss_rail_regs_tb;
	logic sys_clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic cmd_valid, cmd_write, rd_valid, cmd_reject, commit, ok_w, rej_w;
	rss_pkg::rss_cmd_type cmd_code;
	rss_pkg::rss_word_type cmd_wdata, rd_data, rd_w, v;
	logic [0:0] page;
	// Both rails on and good, no faults
	logic [17:0] st = 18'h3_c000;
	logic [1:0][15:0] tgt = 32'h0000_0000;
	logic [1:0][15:0] up, dly, dn, rt;
	int err_total = 0;
	int cmp_count = 0;
	int cyc = 0;
	localparam logic [15:0] EXP [18] = '{16'h0001, 16'h1000, 16'h0002,
		16'h0004, 16'h2000, 16'h2008, 16'h4010, 16'h4010, 16'h8000,
		16'h8000, 16'h8000, 16'h8000, 16'h8020, 16'h8020, 16'h0800,
		16'h0800, 16'h0040, 16'h0040};

	always #12.5 sys_clk_in = ~sys_clk_in;

	rss_host_model i_rss_host_model (.sys_clk_in(sys_clk_in),
		.cmd_valid_out(cmd_valid), .cmd_write_out(cmd_write),
		.cmd_code_out(cmd_code), .cmd_wdata_out(cmd_wdata),
		.rd_data_in(rd_data), .rd_valid_in(rd_valid),
		.cmd_reject_in(cmd_reject));

	rss_rail_regs #(.OUTPUTS(2)) i_rss_rail_regs (.sys_clk_in(sys_clk_in),
		.srst_in(srst_in), .cmd_valid_in(cmd_valid),
		.cmd_write_in(cmd_write), .cmd_code_in(cmd_code),
		.cmd_wdata_in(cmd_wdata), .rd_data_out(rd_data),
		.rd_valid_out(rd_valid), .cmd_reject_out(cmd_reject),
		.commit_out(commit), .page_out(page), .rail_on_in(st[17:16]),
		.power_good_in(st[15:14]), .vout_ov_in(st[13:12]),
		.vout_uv_in(st[11:10]), .vout_ceil_in(st[9:8]),
		.iout_oc_in(st[7:6]), .vin_uv_in(st[5]), .input_fault_in(st[4]),
		.temp_in(st[3]), .cml_in(st[2]), .mfr_in(st[1]), .other_in(st[0]),
		.vout_target_in(tgt), .ramp_up_out(up), .turnoff_delay_out(dly),
		.ramp_down_out(dn), .ramp_target_out(rt));

	task automatic end_of_test();
		if (err_total == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input rss_pkg::rss_word_type seen,
		input rss_pkg::rss_word_type exp, input string msg);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s got %h want %h", $time, msg,
				seen, exp);
		end
	endtask

	task automatic wr(input rss_pkg::rss_cmd_type c,
		input rss_pkg::rss_word_type d, input logic rej);
		i_rss_host_model.cmd(1'b1, c, d, rd_w, ok_w, rej_w);
		chk({15'h0000, rej_w}, {15'h0000, rej}, "refusal");
	endtask

	task automatic rd_chk(input rss_pkg::rss_cmd_type c,
		input rss_pkg::rss_word_type exp, input string msg);
		i_rss_host_model.cmd(1'b0, c, 16'h0000, v, ok_w, rej_w);
		chk({15'h0000, ok_w}, 16'h0001, "read valid");
		chk(v, exp, msg);
	endtask

	task automatic t_defaults();
		for (int p = 0; p < 2; p++) begin
			wr(8'h00, 16'(p), 1'b0);
			rd_chk(8'h61, 16'h01f4, "rise");
			rd_chk(8'h64, 16'h0000, "delay");
			rd_chk(8'h65, 16'h01f4, "fall");
			chk(up[p], 16'h01f4, "rise out");
			chk(dly[p], 16'h0000, "delay out");
			chk(dn[p], 16'h01f4, "fall out");
		end
	endtask

	task automatic t_commit();
		wr(8'h00, 16'h0001, 1'b0);
		chk({15'h0000, page}, 16'h0001, "page");
		tgt = 32'h1234_0abc;
		wr(8'h61, 16'h2710, 1'b0);
		wr(8'h64, 16'h03e8, 1'b0);
		wr(8'h65, 16'h0000, 1'b0);
		rd_chk(8'h61, 16'h2710, "pending");
		chk(up[1], 16'h01f4, "rise held");
		chk(dn[1], 16'h01f4, "fall held");
		wr(8'he7, 16'h0000, 1'b0);
		chk({15'h0000, commit}, 16'h0001, "commit");
		chk(up[1], 16'h2710, "rise new");
		chk(dly[1], 16'h03e8, "delay new");
		chk(dn[1], 16'h0000, "fall new");
		chk(up[0], 16'h01f4, "page 0");
		chk(rt[1], 16'h1234, "target 1");
		chk(rt[0], 16'h0abc, "target 0");
		// A target change alone must wait for another commit
		tgt = 32'h5555_0abc;
		repeat (2) @(negedge sys_clk_in);
		chk(rt[1], 16'h1234, "target held");
		wr(8'he7, 16'h0000, 1'b0);
		chk(rt[1], 16'h5555, "retarget");
	endtask

	task automatic t_refuse();
		wr(8'h61, 16'h2711, 1'b1);
		wr(8'h64, 16'h03e9, 1'b1);
		wr(8'h65, 16'h2711, 1'b1);
		wr(8'h78, 16'h00ff, 1'b1);
		wr(8'h79, 16'hffff, 1'b1);
		wr(8'h7a, 16'h00ff, 1'b1);
		wr(8'h00, 16'h0002, 1'b1);
		wr(8'h55, 16'h0000, 1'b1);
		i_rss_host_model.cmd(1'b0, 8'he7, 16'h0000, v, ok_w, rej_w);
		chk({15'h0000, rej_w}, 16'h0001, "commit read");
		rd_chk(8'h61, 16'h2710, "rise kept");
		rd_chk(8'h64, 16'h03e8, "delay kept");
		rd_chk(8'h65, 16'h0000, "fall kept");
	endtask

	task automatic t_status();
		for (int i = 0; i < 18; i++) begin
			st = 18'h3_c000 ^ (18'h0_0001 << i);
			// Other output's page selected for the summary reads
			wr(8'h00, {15'h0000, ~i[0]}, 1'b0);
			rd_chk(8'h79, EXP[i], "word");
			rd_chk(8'h78, {8'h00, EXP[i][7:0]}, "byte");
			for (int p = 0; p < 2; p++) begin
				wr(8'h00, 16'(p), 1'b0);
				rd_chk(8'h7a, {8'h00, st[12+p], 2'b00, st[10+p], st[8+p],
					3'b000}, "vdetail");
			end
		end
	endtask

	always @(posedge sys_clk_in) begin
		cyc++;
		if (cyc == 4000) begin
			err_total++;
			end_of_test();
		end
	end

	initial begin
		repeat (3) @(negedge sys_clk_in);
		srst_in = 1'b0;
		t_defaults();
		t_commit();
		t_refuse();
		t_status();
		end_of_test();
	end
endmodule
